// *** common/fpec_pkg.sv ***
/*
 shared constants of the flash program/erase sequencer: register offsets,
 control field positions, operation codes, timing counts and state codes.
 assumes a 100 MHz system clock.
*/
`default_nettype none
package fpec_pkg;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_IEN = 8'h08;
    localparam logic [7:0] ADDR_ICLR = 8'h0C;
    localparam int BIT_START = 15;
    localparam int BIT_FLASH_WRITE_ENABLE = 14;
    localparam int BIT_FAULT = 13;
    localparam int BIT_STBY = 12;
    localparam int OP_LSB = 0;
    localparam int STAT_DONE = 0;
    localparam int STAT_FAULT = 1;
    localparam logic [15:0] CTRL_RESET = 16'h0000;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
    localparam logic [3:0] OP_WORD = 4'h0;
    localparam logic [3:0] OP_DWORD = 4'h1;
    localparam logic [3:0] OP_ROW = 4'h2;
    localparam logic [3:0] OP_PAGE = 4'h3;
    localparam logic [3:0] OP_BULK_A = 4'hA;
    localparam logic [3:0] OP_BULK_D = 4'hD;
    localparam logic [1:0] KIND_WORD = 2'h0;
    localparam logic [1:0] KIND_DWORD = 2'h1;
    localparam logic [1:0] KIND_ROW = 2'h2;
    localparam logic [1:0] KIND_BULK = 2'h3;
    localparam int CLK_NS = 10;
    localparam int T_WORD_NS = 20000;
    localparam int T_DWORD_NS = 40000;
    localparam int T_ROW_NS = 2000000;
    localparam int T_BULK_NS = 40000000;
    localparam int T_WAKE_NS = 10000;
    localparam int WORD_CYC = (T_WORD_NS + CLK_NS - 1) / CLK_NS;
    localparam int DWORD_CYC = (T_DWORD_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_CYC = (T_ROW_NS + CLK_NS - 1) / CLK_NS;
    localparam int BULK_CYC = (T_BULK_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_CYC = (T_WAKE_NS + CLK_NS - 1) / CLK_NS;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_RUN = 3'h2,
        ST_END = 3'h4
    } fpec_state_t;
    // reserved codes fall through to the default and start nothing
    function automatic logic op_valid(input logic [3:0] op);
        case (op)
            OP_WORD, OP_DWORD, OP_ROW, OP_PAGE, OP_BULK_A, OP_BULK_D: op_valid = 1'b1;
            default: op_valid = 1'b0;
        endcase
    endfunction
    function automatic logic [1:0] op_kind(input logic [3:0] op);
        case (op)
            OP_DWORD: op_kind = KIND_DWORD;
            OP_ROW, OP_PAGE: op_kind = KIND_ROW;
            OP_BULK_A, OP_BULK_D: op_kind = KIND_BULK;
            default: op_kind = KIND_WORD;
        endcase
    endfunction
endpackage
`default_nettype wire

// *** common/fpec_seq_if.sv ***
/*
 link between the sequencer control and its operation timer.
 assumes both ends run on the same clock and clock enable.
*/
`timescale 1ns/10ps
`default_nettype none
interface fpec_seq_if;
    logic launch;
    logic [1:0] kind;
    logic abort;
    logic busy;
    logic done;
    modport ctl (output launch, output kind, output abort, input busy, input done);
    modport tmr (input launch, input kind, input abort, output busy, output done);
endinterface
`default_nettype wire

// *** hdl/fpec_op_timer.sv ***
/*
 self-timed operation counter: loads a cycle count chosen by the kind of
 operation on launch and signals done on the last cycle.
 assumes launch is only raised while not busy.
*/
`timescale 1ns/10ps
`default_nettype none
module fpec_op_timer #(
    parameter int unsigned CNT_W = 24,
    parameter int unsigned WORD_CYC = 1,
    parameter int unsigned DWORD_CYC = 1,
    parameter int unsigned ROW_CYC = 1,
    parameter int unsigned BULK_CYC = 1
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    fpec_seq_if.tmr seq
);
    logic [CNT_W-1:0] cnt_r;
    logic busy_r;

    function automatic logic [CNT_W-1:0] kind_cycles(input logic [1:0] k);
        case (k)
            fpec_pkg::KIND_DWORD: kind_cycles = CNT_W'(DWORD_CYC);
            fpec_pkg::KIND_ROW: kind_cycles = CNT_W'(ROW_CYC);
            fpec_pkg::KIND_BULK: kind_cycles = CNT_W'(BULK_CYC);
            default: kind_cycles = CNT_W'(WORD_CYC);
        endcase
    endfunction

    assign seq.busy = busy_r;
    assign seq.done = clk_en_in && busy_r && (cnt_r == CNT_W'(1));

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            busy_r <= 1'b0;
            cnt_r <= '0;
        end
        else if (clk_en_in)
        begin
            if (seq.abort)
                busy_r <= 1'b0;
            else if (seq.launch)
            begin
                busy_r <= 1'b1;
                cnt_r <= kind_cycles(seq.kind);
            end
            else if (busy_r)
            begin
                if (cnt_r == CNT_W'(1))
                    busy_r <= 1'b0;
                cnt_r <= cnt_r - CNT_W'(1);
            end
        end
    end
endmodule // fpec_op_timer
`default_nettype wire

// *** hdl/fpec_top.sv ***
/*
 flash program/erase sequencer: AHB-Lite register slave, control register,
 operation launch and termination, regulator idle handling, interrupt.
 assumes rst_n_in is the power-on reset; sys_rst_n_in gathers the other
 reset sources and is synchronous to clk_in.
*/
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
`default_nettype none
// Contract
// - start launches the chosen operation, timed inside; hardware clears start afterwards.
// - write-enable set allows operations; clear inhibits every program or erase.
// - fault set on improper or terminated attempt; left alone on normal completion.
// - standby bit sends the regulator to standby during idle, else stays active.
// - with standby set, flash stays unavailable for a wake delay after idle.
// - codes 1111, 1110, 1100, 1011 reserved; unlisted codes start nothing.
// - one program code writes two adjacent words in one execution.
// - power-save instruction is ignored while an operation is in progress.
// - control bits return to zero only on power-on reset.
// - control bits 11 to 4 ignore writes and read as zero.
module fpec_top #(
    parameter int unsigned CNT_W = 24,
    parameter int unsigned WORD_CYC = fpec_pkg::WORD_CYC,
    parameter int unsigned DWORD_CYC = fpec_pkg::DWORD_CYC,
    parameter int unsigned ROW_CYC = fpec_pkg::ROW_CYC,
    parameter int unsigned BULK_CYC = fpec_pkg::BULK_CYC,
    parameter int unsigned WAKE_CYC = fpec_pkg::WAKE_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic sys_rst_n_in,
    input wire logic clk_en_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    input wire logic idle_in,
    input wire logic power_save_in,
    output logic sleep_grant_out,
    output logic regulator_standby_out,
    output logic flash_ready_out,
    output logic flash_go_out,
    output logic [3:0] flash_op_out,
    output logic flash_double_word_out,
    output logic flash_active_out,
    input wire logic flash_fault_in,
    output logic irq_out
);
    if (CNT_W < 2 || CNT_W > 31 || WORD_CYC < 1 || DWORD_CYC < 1 || ROW_CYC < 1
        || BULK_CYC < 1 || WAKE_CYC < 1 || BULK_CYC >= (1 << CNT_W)
        || ROW_CYC >= (1 << CNT_W) || WAKE_CYC >= (1 << CNT_W))
    begin : g_bad_param
        $error("fpec_top: cycle counts must be at least 1 and fit CNT_W bits");
    end

    fpec_pkg::fpec_state_t state_r;
    fpec_pkg::fpec_state_t state_nxt;
    logic ctrl_start_r;
    logic ctrl_flash_write_enable_r;
    logic ctrl_fault_r;
    logic ctrl_standby_r;
    logic [3:0] ctrl_op_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_en_r;
    logic wr_pend_r;
    logic [7:0] wr_addr_r;
    logic [31:0] hrdata_r;
    logic [31:0] rd_word;
    logic [15:0] ctrl_word;
    logic idle_d_r;
    logic [CNT_W-1:0] wake_cnt_r;
    logic go_r;
    logic [3:0] run_op_r;
    logic dword_r;
    logic addr_ok;
    logic wr_now;
    logic wr_ctrl;
    logic wr_ien;
    logic wr_iclr;
    logic op_ok;
    logic term;
    logic fault_set;
    logic [1:0] stat_set;

    fpec_seq_if seq ();

    fpec_op_timer #(
        .CNT_W(CNT_W),
        .WORD_CYC(WORD_CYC),
        .DWORD_CYC(DWORD_CYC),
        .ROW_CYC(ROW_CYC),
        .BULK_CYC(BULK_CYC)
    ) u_timer (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in),
        .seq(seq.tmr)
    );

    // zero wait states; a frozen clock enable stalls the bus instead of losing a beat
    assign hreadyout_out = clk_en_in;
    assign hresp_out = 1'b0;
    assign hrdata_out = hrdata_r;
    assign addr_ok = hsel_in && htrans_in[1] && hready_in && clk_en_in;
    assign wr_now = wr_pend_r && clk_en_in;
    assign wr_ctrl = wr_now && (wr_addr_r == fpec_pkg::ADDR_CTRL);
    assign wr_ien = wr_now && (wr_addr_r == fpec_pkg::ADDR_IEN);
    assign wr_iclr = wr_now && (wr_addr_r == fpec_pkg::ADDR_ICLR);

    assign ctrl_word = {ctrl_start_r, ctrl_flash_write_enable_r, ctrl_fault_r, ctrl_standby_r,
                        8'h00, ctrl_op_r};

    always_comb
    begin
        case (haddr_in[7:0])
            fpec_pkg::ADDR_CTRL: rd_word = {16'h0000, ctrl_word};
            fpec_pkg::ADDR_STAT: rd_word = {30'h0000_0000, irq_stat_r};
            fpec_pkg::ADDR_IEN: rd_word = {30'h0000_0000, irq_en_r};
            default: rd_word = 32'h0000_0000;
        endcase
    end

    // read data is sampled in the address phase so it comes from a flip-flop
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata_r <= 32'h0000_0000;
        end
        else if (addr_ok)
        begin
            wr_pend_r <= hwrite_in && (hsize_in == fpec_pkg::HSIZE_WORD);
            wr_addr_r <= haddr_in[7:0];
            hrdata_r <= hwrite_in ? 32'h0000_0000 : rd_word;
        end
        else if (clk_en_in)
            wr_pend_r <= 1'b0;
    end

    assign op_ok = ctrl_flash_write_enable_r && fpec_pkg::op_valid(ctrl_op_r);
    assign term = flash_fault_in || !sys_rst_n_in;
    assign seq.kind = fpec_pkg::op_kind(ctrl_op_r);

    always_comb
    begin
        state_nxt = state_r;
        seq.launch = 1'b0;
        seq.abort = 1'b0;
        fault_set = 1'b0;
        case (state_r)
            fpec_pkg::ST_IDLE:
            begin
                if (ctrl_start_r && flash_ready_out)
                begin
                    if (op_ok)
                    begin
                        seq.launch = 1'b1;
                        state_nxt = fpec_pkg::ST_RUN;
                    end
                    else
                    begin
                        fault_set = 1'b1;
                        state_nxt = fpec_pkg::ST_END;
                    end
                end
            end
            fpec_pkg::ST_RUN:
            begin
                if (term)
                begin
                    seq.abort = 1'b1;
                    fault_set = 1'b1;
                    state_nxt = fpec_pkg::ST_END;
                end
                else if (seq.done)
                    state_nxt = fpec_pkg::ST_END;
            end
            fpec_pkg::ST_END: state_nxt = fpec_pkg::ST_IDLE;
            default: state_nxt = fpec_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
            state_r <= fpec_pkg::ST_IDLE;
        else if (clk_en_in)
            state_r <= state_nxt;
    end

    // only the power-on reset touches the control bits
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            ctrl_start_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_START];
            ctrl_flash_write_enable_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_FLASH_WRITE_ENABLE];
            ctrl_fault_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_FAULT];
            ctrl_standby_r <= fpec_pkg::CTRL_RESET[fpec_pkg::BIT_STBY];
            ctrl_op_r <= fpec_pkg::CTRL_RESET[fpec_pkg::OP_LSB +: 4];
        end
        else if (clk_en_in)
        begin
            if (wr_ctrl)
            begin
                ctrl_flash_write_enable_r <= hwdata_in[fpec_pkg::BIT_FLASH_WRITE_ENABLE];
                ctrl_standby_r <= hwdata_in[fpec_pkg::BIT_STBY];
                ctrl_op_r <= hwdata_in[fpec_pkg::OP_LSB +: 4];
            end
            if (wr_ctrl && hwdata_in[fpec_pkg::BIT_START])
                ctrl_start_r <= 1'b1;
            else if (state_r == fpec_pkg::ST_END)
                ctrl_start_r <= 1'b0;
            if (fault_set)
                ctrl_fault_r <= 1'b1;
            else if (wr_ctrl)
                ctrl_fault_r <= hwdata_in[fpec_pkg::BIT_FAULT];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            go_r <= 1'b0;
            run_op_r <= 4'h0;
            dword_r <= 1'b0;
        end
        else if (clk_en_in)
        begin
            go_r <= seq.launch;
            if (seq.launch)
            begin
                run_op_r <= ctrl_op_r;
                dword_r <= (ctrl_op_r == fpec_pkg::OP_DWORD);
            end
        end
    end

    assign flash_go_out = go_r;
    assign flash_op_out = run_op_r;
    assign flash_double_word_out = dword_r;
    assign flash_active_out = (state_r == fpec_pkg::ST_RUN);

    // wake delay counts from the edge where idle ends
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            idle_d_r <= 1'b0;
            wake_cnt_r <= '0;
        end
        else if (clk_en_in)
        begin
            idle_d_r <= idle_in;
            if (idle_d_r && !idle_in && ctrl_standby_r)
                wake_cnt_r <= CNT_W'(WAKE_CYC);
            else if (wake_cnt_r != '0)
                wake_cnt_r <= wake_cnt_r - CNT_W'(1);
        end
    end

    assign regulator_standby_out = idle_in && ctrl_standby_r;
    // the exit edge itself counts as unavailable, the counter only loads one cycle later
    assign flash_ready_out = !regulator_standby_out && (wake_cnt_r == '0)
                             && !(idle_d_r && !idle_in && ctrl_standby_r);
    assign sleep_grant_out = power_save_in && (state_r == fpec_pkg::ST_IDLE);

    assign stat_set[fpec_pkg::STAT_DONE] = (state_r == fpec_pkg::ST_END);
    assign stat_set[fpec_pkg::STAT_FAULT] = fault_set;

    // a new event in the clearing cycle survives
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            irq_stat_r <= fpec_pkg::IRQ_RESET;
            irq_en_r <= fpec_pkg::IRQ_RESET;
        end
        else if (clk_en_in)
        begin
            if (!sys_rst_n_in)
                irq_en_r <= fpec_pkg::IRQ_RESET;
            else if (wr_ien)
                irq_en_r <= hwdata_in[1:0];
            irq_stat_r <= (sys_rst_n_in ? (irq_stat_r & ~(wr_iclr ? hwdata_in[1:0] : 2'h0))
                                        : fpec_pkg::IRQ_RESET) | stat_set;
        end
    end

    assign irq_out = |(irq_stat_r & irq_en_r);

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_launch;
        clk_en_in && (state_r == fpec_pkg::ST_IDLE) && ctrl_start_r && flash_ready_out && op_ok;
    endsequence
    sequence s_refuse;
        clk_en_in && (state_r == fpec_pkg::ST_IDLE) && ctrl_start_r && flash_ready_out && !op_ok;
    endsequence
    sequence s_finish;
        clk_en_in && (state_r == fpec_pkg::ST_END) && !(wr_ctrl && hwdata_in[fpec_pkg::BIT_START]);
    endsequence

    property p_launch_go;
        s_launch |=> flash_go_out && (state_r == fpec_pkg::ST_RUN) && ctrl_start_r;
    endproperty
    a_launch_go: assert property (p_launch_go) else $error("start did not launch");

    property p_start_clears;
        s_finish |=> !ctrl_start_r && (state_r == fpec_pkg::ST_IDLE);
    endproperty
    a_start_clears: assert property (p_start_clears) else $error("start not cleared");

    property p_flash_write_enable_gate;
        flash_go_out |-> $past(ctrl_flash_write_enable_r);
    endproperty
    a_flash_write_enable_gate: assert property (p_flash_write_enable_gate) else $error("launch without enable");

    property p_refuse_fault;
        s_refuse |=> ctrl_fault_r && !flash_go_out ##1 !ctrl_start_r;
    endproperty
    a_refuse_fault: assert property (p_refuse_fault) else $error("bad start not flagged");

    property p_standby;
        regulator_standby_out |-> ctrl_standby_r && idle_in && !flash_ready_out;
    endproperty
    a_standby: assert property (p_standby) else $error("standby without select");

    property p_wake;
        clk_en_in && idle_d_r && !idle_in && ctrl_standby_r |-> !flash_ready_out ##1 !flash_ready_out;
    endproperty
    a_wake: assert property (p_wake) else $error("flash ready during wake");

    property p_valid_op;
        flash_go_out |-> fpec_pkg::op_valid(flash_op_out);
    endproperty
    a_valid_op: assert property (p_valid_op) else $error("reserved code launched");

    property p_dword;
        flash_double_word_out |-> (flash_op_out == fpec_pkg::OP_DWORD);
    endproperty
    a_dword: assert property (p_dword) else $error("double word on wrong code");

    property p_no_sleep;
        (state_r != fpec_pkg::ST_IDLE) |-> !sleep_grant_out;
    endproperty
    a_no_sleep: assert property (p_no_sleep) else $error("sleep during operation");

    property p_keep_ctrl;
        !sys_rst_n_in && clk_en_in && !wr_ctrl |=> $stable(ctrl_flash_write_enable_r) && $stable(ctrl_op_r);
    endproperty
    a_keep_ctrl: assert property (p_keep_ctrl) else $error("control lost on reset");

    property p_pad_zero;
        hrdata_out[11:4] == 8'h00 && hrdata_out[31:16] == 16'h0000;
    endproperty
    a_pad_zero: assert property (p_pad_zero) else $error("unused bits read nonzero");

    property p_no_cancel;
        clk_en_in && (state_r == fpec_pkg::ST_RUN) && !seq.done && !term |=> ctrl_start_r;
    endproperty
    a_no_cancel: assert property (p_no_cancel) else $error("operation cancelled");

    property p_busy_match;
        (state_r == fpec_pkg::ST_RUN) == seq.busy;
    endproperty
    a_busy_match: assert property (p_busy_match) else $error("timer and sequencer disagree");
endmodule // fpec_top
`default_nettype wire

// *** dv/fpec_flash_model.sv ***
/*
 flash array model: counts launches and busy cycles, latches the op seen.
 assumes one launch pulse per operation and a level active signal.
*/
`timescale 1ns/10ps
`default_nettype none
module fpec_flash_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic active_in,
    input wire logic [3:0] op_in,
    input wire logic dword_in,
    input wire logic fault_req_in,
    output logic fault_out,
    output logic [15:0] act_cnt_out = 16'h0000,
    output logic [15:0] go_cnt_out = 16'h0000,
    output logic [3:0] op_seen_out = 4'h0,
    output logic dword_seen_out = 1'b0
);
    // an idle array reports no fault, so a request only bites mid-operation
    assign fault_out = fault_req_in & active_in;
    always @(posedge clk_in)
    begin
        if (go_in === 1'b1)
        begin
            go_cnt_out <= go_cnt_out + 16'h0001;
            act_cnt_out <= 16'h0001;
            op_seen_out <= op_in;
            dword_seen_out <= dword_in;
        end
        else if (active_in === 1'b1)
            act_cnt_out <= act_cnt_out + 16'h0001;
    end
endmodule // fpec_flash_model
`default_nettype wire

// *** dv/tb_flash_program_erase_control.sv ***
/*
 self-checking bench of the flash sequencer over its register bus.
 assumes short timing parameters and a single bus slave.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_flash_program_erase_control;
    localparam int N_W = 3;
    localparam int N_D = 5;
    localparam int N_R = 8;
    localparam int N_B = 12;
    localparam int N_WK = 4;
    localparam logic [7:0] A_C = fpec_pkg::ADDR_CTRL;
    localparam logic [7:0] A_S = fpec_pkg::ADDR_STAT;
    localparam logic [7:0] A_E = fpec_pkg::ADDR_IEN;
    localparam logic [7:0] A_K = fpec_pkg::ADDR_ICLR;
    localparam logic [31:0] S = 32'h0000_8000;
    localparam logic [31:0] W = 32'h0000_4000;
    localparam logic [31:0] Y = 32'h0000_1000;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic sys_rst_n_in = 1'b1;
    logic clk_en_in = 1'b1;
    logic hsel_in = 1'b0;
    logic [31:0] haddr_in = 32'h0000_0000;
    logic [1:0] htrans_in = 2'h0;
    logic hwrite_in = 1'b0;
    logic [2:0] hsize_in = 3'h2;
    logic [31:0] hwdata_in = 32'h0000_0000;
    logic idle_in = 1'b0;
    logic power_save_in = 1'b0;
    logic fault_req = 1'b0;
    logic [31:0] hrdata_out;
    logic hreadyout_out, hresp_out, sleep_grant_out, regulator_standby_out;
    logic flash_ready_out, flash_go_out, flash_double_word_out, flash_active_out;
    logic flash_fault_in, irq_out, dw_seen;
    logic [3:0] flash_op_out, op_seen;
    logic [15:0] act_cnt, go_cnt;
    logic [31:0] rd;
    int mismatches = 0;
    int n_tests = 0;

    always #5 clk_in = ~clk_in;

    fpec_top #(.WORD_CYC(N_W), .DWORD_CYC(N_D), .ROW_CYC(N_R), .BULK_CYC(N_B),
        .WAKE_CYC(N_WK)) u_fpec_top (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .sys_rst_n_in(sys_rst_n_in), .clk_en_in(clk_en_in), .hsel_in(hsel_in),
        .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
        .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hreadyout_out),
        .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
        .idle_in(idle_in), .power_save_in(power_save_in),
        .sleep_grant_out(sleep_grant_out), .regulator_standby_out(regulator_standby_out),
        .flash_ready_out(flash_ready_out), .flash_go_out(flash_go_out),
        .flash_op_out(flash_op_out), .flash_double_word_out(flash_double_word_out),
        .flash_active_out(flash_active_out), .flash_fault_in(flash_fault_in),
        .irq_out(irq_out));

    fpec_flash_model u_fpec_flash_model (.clk_in(clk_in), .go_in(flash_go_out),
        .active_in(flash_active_out), .op_in(flash_op_out),
        .dword_in(flash_double_word_out), .fault_req_in(fault_req),
        .fault_out(flash_fault_in), .act_cnt_out(act_cnt), .go_cnt_out(go_cnt),
        .op_seen_out(op_seen), .dword_seen_out(dw_seen));

    task conclude;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task chk(input logic ok, input string msg);
        n_tests++;
        if (ok !== 1'b1)
        begin
            mismatches++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task hang;
        chk(1'b0, "wait bound exhausted");
        conclude;
    endtask

    task tick(input int n);
        repeat (n) @(posedge clk_in);
    endtask

    // hready is this slave's own, so a stall only comes from clk_en_in
    task rdy;
        int n;
        n = 0;
        @(posedge clk_in);
        while (hreadyout_out !== 1'b1)
        begin
            n++;
            if (n > 50)
                hang;
            @(posedge clk_in);
        end
    endtask

    task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        hsel_in <= 1'b1;
        haddr_in <= {24'h00_0000, a};
        hwrite_in <= wr;
        htrans_in <= 2'h2;
        hsize_in <= fpec_pkg::HSIZE_WORD;
        rdy;
        htrans_in <= 2'h0;
        hsel_in <= 1'b0;
        hwdata_in <= wd;
        rdy;
        rd = hrdata_out;
        chk(hresp_out === 1'b0, "response not okay");
    endtask

    task poll;
        int n;
        n = 0;
        do
        begin
            bus(1'b0, A_C, 32'h0000_0000);
            n++;
            if (n > 60)
                hang;
        end
        while (rd[15] !== 1'b0);
    endtask

    task run_op(input logic [31:0] cfg, input logic bad, input int n);
        logic [15:0] g;
        g = go_cnt;
        bus(1'b1, A_C, cfg);
        bus(1'b1, A_C, cfg | S);
        poll;
        chk(rd[13] === bad, "fault flag");
        chk(go_cnt === g + {15'h0000, !bad}, "launch count");
        if (!bad)
        begin
            chk(act_cnt === n[15:0], "op length");
            chk(op_seen === cfg[3:0], "op code");
            chk(dw_seen === (cfg[3:0] == 4'h1), "double word");
        end
    endtask

    task t_reset;
        bus(1'b0, A_C, 32'h0000_0000);
        chk(rd === 32'h0000_0000, "ctrl reset");
        bus(1'b1, A_C, 32'hFFFF_6FF3);
        bus(1'b0, A_C, 32'h0000_0000);
        chk(rd === 32'h0000_6003, "unused bits");
        bus(1'b1, 8'h40, 32'hFFFF_FFFF);
        bus(1'b0, 8'h40, 32'h0000_0000);
        chk(rd === 32'h0000_0000, "unmapped read");
    endtask

    task t_ops;
        logic [3:0] codes [6];
        int lens [6];
        codes = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hA, 4'hD};
        lens = '{N_W, N_D, N_R, N_R, N_B, N_B};
        foreach (codes[i])
            run_op(W | codes[i], 1'b0, lens[i]);
    endtask

    task t_bad;
        for (int i = 4; i < 16; i++)
            if (i != 10 && i != 13)
                run_op(W | i[3:0], 1'b1, 0);
        run_op(32'h0000_0000, 1'b1, 0);
        run_op(32'h0000_000D, 1'b1, 0);
    endtask

    task t_hold;
        bus(1'b1, A_C, W | 32'h0000_0002);
        bus(1'b1, A_C, W | S | 32'h0000_0002);
        power_save_in <= 1'b1;
        bus(1'b1, A_C, W | 32'h0000_0002);
        chk(sleep_grant_out === 1'b0, "sleep granted mid-op");
        bus(1'b0, A_C, 32'h0000_0000);
        chk(rd[15] === 1'b1, "start cancelled");
        poll;
        chk(act_cnt === N_R[15:0], "op cut short");
        tick(1);
        chk(sleep_grant_out === 1'b1, "sleep refused idle");
        power_save_in <= 1'b0;
    endtask

    task t_term;
        bus(1'b1, A_C, W | 32'h0000_000D);
        bus(1'b1, A_C, W | S | 32'h0000_000D);
        tick(3);
        fault_req <= 1'b1;
        poll;
        fault_req <= 1'b0;
        chk(rd[13] === 1'b1 && act_cnt < N_B[15:0], "array fault");
        bus(1'b0, A_S, 32'h0000_0000);
        chk(rd[1] === 1'b1, "fault status");
        // other resets stop the op but keep the control bits
        bus(1'b1, A_C, W | 32'h0000_0003);
        bus(1'b1, A_C, W | S | 32'h0000_0003);
        tick(2);
        sys_rst_n_in <= 1'b0;
        tick(2);
        sys_rst_n_in <= 1'b1;
        poll;
        chk(rd === 32'h0000_6003, "kept over sys reset");
        rst_n_in <= 1'b0;
        tick(2);
        rst_n_in <= 1'b1;
        bus(1'b0, A_C, 32'h0000_0000);
        chk(rd === 32'h0000_0000, "power-on clear");
    endtask

    task t_idle;
        int n;
        idle_in <= 1'b1;
        tick(2);
        chk(regulator_standby_out === 1'b0 && flash_ready_out === 1'b1, "reg on");
        bus(1'b1, A_C, Y | W);
        bus(1'b1, A_C, Y | W | S);
        tick(2);
        chk(regulator_standby_out === 1'b1 && flash_ready_out === 1'b0, "standby");
        chk(flash_active_out === 1'b0, "launch while asleep");
        idle_in <= 1'b0;
        n = 0;
        do
        begin
            tick(1);
            n++;
        end
        while (flash_ready_out !== 1'b1 && n < 20);
        chk(n >= N_WK && n <= N_WK + 2, "wake delay");
        poll;
        chk(act_cnt === N_W[15:0] && rd[13] === 1'b0, "pending op");
    endtask

    task t_irq;
        bus(1'b1, A_E, 32'h0000_0001);
        bus(1'b1, A_K, 32'h0000_0003);
        run_op(W | 32'h0000_0001, 1'b0, N_D);
        chk(irq_out === 1'b1, "irq on done");
        bus(1'b0, A_S, 32'h0000_0000);
        chk(rd === 32'h0000_0001, "status done");
        bus(1'b1, A_K, 32'h0000_0001);
        tick(1);
        chk(irq_out === 1'b0, "irq cleared");
        bus(1'b0, A_K, 32'h0000_0000);
        chk(rd === 32'h0000_0000, "clear reads zero");
        bus(1'b1, A_E, 32'h0000_0000);
        run_op(W, 1'b0, N_W);
        bus(1'b0, A_S, 32'h0000_0000);
        chk(irq_out === 1'b0 && rd[0] === 1'b1, "masked irq");
    endtask

    initial
    begin
        tick(3);
        rst_n_in <= 1'b1;
        tick(1);
        t_reset;
        t_ops;
        t_bad;
        t_hold;
        t_term;
        t_idle;
        t_irq;
        conclude;
    end
endmodule // tb_flash_program_erase_control
`default_nettype wire
